/* logic/hpm_playback_ctrl.sv */
// Playback state, mode selection and streamed drive level control
`timescale 1ns/1ps
`default_nettype none
module hpm_playback_ctrl
  import hpm_pkg::*;
#(
  parameter int BOOT_LEN = hpm_pkg::BOOT_CYCLES,
  parameter int COUNT_W  = 16
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic [2:0]         operationMode,
  input  wire logic               standbySelect,
  input  wire logic               boostAssist,
  input  wire logic               actuatorIsErm,
  input  wire logic               rapidStopEnable,
  input  wire logic [7:0]         streamedDriveLevel,
  input  wire logic [7:0]         nominalDriveCeiling,
  input  wire logic [7:0]         absoluteDriveCeiling,
  input  wire logic [7:0]         minDutyThreshold,
  input  wire logic [1:0]         edgeSelect,
  input  wire logic               sequenceLaunch,
  input  wire logic               sequenceDone,
  input  wire logic               faultDetected,
  input  wire logic               faultPending,
  input  wire logic [COUNT_W-1:0] halfPeriodCycles,
  input  wire logic               triggerStreamPin,
  input  wire logic               driveReady,
  output hpm_pkg::hpm_state_t     systemState,
  output logic                    sequencePlay,
  output logic                    switchTick,
  output logic                    polarityStatus,
  output logic [7:0]              measuredDuty,
  output logic                    driveValid,
  output logic [7:0]              driveAmplitude,
  output logic                    driveStageOn,
  output logic                    driveReverse,
  output logic                    drivePhaseShift,
  output logic [7:0]              transientCeiling,
  output logic                    rapidStopPermit
);
  import hpm_pkg::*;

  localparam logic [31:0]        BOOT_LAST = 32'(BOOT_LEN - 1);
  localparam logic [COUNT_W-1:0] COUNT_MAX = '1;
  localparam logic [14:0]        SCALE_DIV = 15'(LEVEL_POS_FULL);

  initial begin
    if (BOOT_LEN < 1 || COUNT_W < 9) $error("hpm_playback_ctrl: bad parameter");
  end

  // Pin synchroniser, then edge history
  logic pinMeta_q, pinSync_q, pinLast_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pinMeta_q <= 1'b0;
      pinSync_q <= 1'b0;
      pinLast_q <= 1'b0;
    end else begin
      pinMeta_q <= triggerStreamPin;
      pinSync_q <= pinMeta_q;
      pinLast_q <= pinSync_q;
    end
  end
  logic pinRise, pinFall, pinEvent;
  assign pinRise  = pinSync_q & ~pinLast_q;
  assign pinFall  = ~pinSync_q & pinLast_q;
  assign pinEvent = (edgeSelect == EDGE_RISE) ? pinRise :
                    (edgeSelect == EDGE_FALL) ? pinFall :
                    (edgeSelect == EDGE_BOTH) ? (pinRise | pinFall) : 1'b0;

  // Playback state group
  hpm_state_t  state_q, state_d;
  logic [31:0] bootCnt_q, bootCnt_d;
  logic [2:0]  driveMode_q, driveMode_d;
  logic        startReq, endReq, streaming;
  always_comb begin
    state_d     = state_q;
    bootCnt_d   = bootCnt_q;
    driveMode_d = driveMode_q;
    unique case (operationMode)
      MODE_REG_STREAM, MODE_PWM_STREAM: startReq = 1'b1;
      MODE_REG_STORE:  startReq = sequenceLaunch;
      MODE_EDGE_STORE: startReq = sequenceLaunch | pinEvent;
      default:         startReq = 1'b0;
    endcase
    startReq = startReq & ~faultPending;
    streaming = (driveMode_q == MODE_REG_STREAM) || (driveMode_q == MODE_PWM_STREAM);
    endReq = streaming ? (operationMode != driveMode_q) : sequenceDone;
    unique case (state_q)
      ST_BOOT: begin
        bootCnt_d = bootCnt_q + 32'h1;
        if (bootCnt_q == BOOT_LAST) state_d = ST_IDLE;
      end
      ST_IDLE, ST_STANDBY: begin
        if (startReq) begin
          state_d     = ST_DRIVE;
          driveMode_d = operationMode;
        end
      end
      ST_DRIVE: begin
        if (endReq) state_d = standbySelect ? ST_STANDBY : ST_IDLE;
      end
    endcase
    if (faultDetected && state_q != ST_BOOT) state_d = ST_IDLE;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q     <= ST_BOOT;
      bootCnt_q   <= 32'h0;
      driveMode_q <= MODE_INACTIVE;
    end else begin
      state_q     <= state_d;
      bootCnt_q   <= bootCnt_d;
      driveMode_q <= driveMode_d;
    end
  end
  assign systemState  = state_q;
  // Store-mode start strobe; the mode of an earlier stream must not mask it
  assign sequencePlay = (state_q != ST_DRIVE) && (state_d == ST_DRIVE) && (driveMode_d > MODE_PWM_STREAM);

  // Duty demodulator group
  logic [COUNT_W-1:0] highCnt_q, highCnt_d, perCnt_q, perCnt_d;
  logic [7:0]         duty_q, duty_d;
  logic [COUNT_W+7:0] dutyRatio;
  always_comb begin
    highCnt_d = highCnt_q;
    perCnt_d  = perCnt_q;
    duty_d    = duty_q;
    dutyRatio = '0;
    if (pinRise) begin
      dutyRatio = ({8'h0, highCnt_q} * (COUNT_W+8)'(DUTY_FULL)) / {8'h0, perCnt_q};
      duty_d    = (perCnt_q == '0) ? DUTY_FULL : 8'(dutyRatio);
      highCnt_d = (COUNT_W)'(1);
      perCnt_d  = (COUNT_W)'(1);
    end else if (perCnt_q == COUNT_MAX) begin
      duty_d = pinSync_q ? DUTY_FULL : LEVEL_ZERO;
    end else begin
      perCnt_d  = perCnt_q + 1'b1;
      highCnt_d = highCnt_q + (COUNT_W)'(pinSync_q);
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      highCnt_q <= '0;
      perCnt_q  <= '0;
      duty_q    <= LEVEL_ZERO;
    end else begin
      highCnt_q <= highCnt_d;
      perCnt_q  <= perCnt_d;
      duty_q    <= duty_d;
    end
  end
  assign measuredDuty = duty_q;

  // Timing group: switching tick and half-period zero crossings
  logic [31:0]        swAcc_q, swAcc_d;
  logic [COUNT_W-1:0] hpCnt_q, hpCnt_d;
  logic               pol_q, pol_d, swTick_q, swTick_d, hpTick;
  always_comb begin
    swAcc_d  = swAcc_q + SWITCH_FREQ_DHZ;
    swTick_d = 1'b0;
    if (swAcc_d >= CLOCK_FREQ_DHZ) begin
      swAcc_d  = swAcc_d - CLOCK_FREQ_DHZ;
      swTick_d = 1'b1;
    end
    hpTick  = (state_q == ST_DRIVE) && (hpCnt_q + 1'b1 >= halfPeriodCycles);
    hpCnt_d = (state_q != ST_DRIVE || hpTick) ? '0 : hpCnt_q + 1'b1;
    pol_d   = hpTick ? ~pol_q : pol_q;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      swAcc_q  <= 32'h0;
      swTick_q <= 1'b0;
      hpCnt_q  <= '0;
      pol_q    <= 1'b0;
    end else begin
      swAcc_q  <= swAcc_d;
      swTick_q <= swTick_d;
      hpCnt_q  <= hpCnt_d;
      pol_q    <= pol_d;
    end
  end
  assign switchTick     = swTick_q;
  assign polarityStatus = pol_q;

  // Commanded level and its scaling
  logic [7:0]  level, ceiling;
  logic [6:0]  absLevel;
  logic [14:0] product;
  logic [7:0]  amplitude;
  logic        negative, dutyOk;
  always_comb begin
    dutyOk = duty_q >= minDutyThreshold;
    if (driveMode_q == MODE_PWM_STREAM)
      level = !dutyOk ? LEVEL_ZERO : boostAssist ? {1'b0, duty_q[7:1]} : (duty_q ^ DUTY_MID);
    else
      level = streamedDriveLevel;
    ceiling  = boostAssist ? nominalDriveCeiling : absoluteDriveCeiling;
    negative = !boostAssist && level[7];
    if (!level[7]) absLevel = level[6:0];
    else if (boostAssist) absLevel = 7'h0;
    else if (level == LEVEL_NEG_FULL) absLevel = LEVEL_POS_FULL;
    else absLevel = 7'(8'h0 - level);
    product   = {8'h0, absLevel} * {7'h0, ceiling};
    amplitude = 8'(product / SCALE_DIV);
  end

  // Sampler group: zero-crossing capture and output stage gating
  logic             stageOn_q, stageOn_d, restart_q, restart_d, pend_q, pend_d;
  logic [WORD_W-1:0] word_q, word_d;
  hpm_word_if #(.WIDTH(WORD_W)) toBuf ();
  hpm_word_if #(.WIDTH(WORD_W)) fromBuf ();
  always_comb begin
    stageOn_d = stageOn_q;
    restart_d = restart_q;
    word_d    = word_q;
    pend_d    = pend_q && !toBuf.ready;
    if (state_q != ST_DRIVE) begin
      stageOn_d = 1'b0;
      restart_d = 1'b0;
    end else if (hpTick) begin
      if (amplitude == LEVEL_ZERO) begin
        stageOn_d = 1'b0;
        restart_d = 1'b0;
      end else if (!stageOn_q) begin
        stageOn_d = restart_q;
        restart_d = 1'b1;
      end
      word_d = '0;
      word_d[W_AMP_LSB +: 8] = stageOn_d ? amplitude : LEVEL_ZERO;
      word_d[W_EN_BIT]       = stageOn_d;
      word_d[W_PHASE_BIT]    = stageOn_d && negative && !actuatorIsErm;
      word_d[W_REV_BIT]      = stageOn_d && negative && actuatorIsErm;
      pend_d = 1'b1;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stageOn_q <= 1'b0;
      restart_q <= 1'b0;
      pend_q    <= 1'b0;
      word_q    <= '0;
    end else begin
      stageOn_q <= stageOn_d;
      restart_q <= restart_d;
      pend_q    <= pend_d;
      word_q    <= word_d;
    end
  end
  assign toBuf.valid = pend_q;
  assign toBuf.data  = word_q;
  assign fromBuf.ready = driveReady;

  // Two-entry buffer toward the output stage
  hpm_pair_buffer #(.WIDTH(WORD_W), .DEPTH(2)) driveBuf (
    .clock   (clock),
    .rst     (rst),
    .inPort  (toBuf),
    .outPort (fromBuf)
  );
  assign driveValid       = fromBuf.valid;
  assign driveAmplitude   = fromBuf.data[W_AMP_LSB +: 8];
  assign driveStageOn     = fromBuf.data[W_EN_BIT];
  assign drivePhaseShift  = fromBuf.data[W_PHASE_BIT];
  assign driveReverse     = fromBuf.data[W_REV_BIT];
  assign transientCeiling = boostAssist ? absoluteDriveCeiling : nominalDriveCeiling;
  assign rapidStopPermit  = rapidStopEnable && (state_q == ST_DRIVE) && streaming;

  a_boot_to_idle: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_BOOT && bootCnt_q == BOOT_LAST) |=> state_q == ST_IDLE) else $error("boot did not end in idle");
  a_start_drive: assert property (@(posedge clock) disable iff (rst)
    ((state_q == ST_IDLE || state_q == ST_STANDBY) && startReq && !faultDetected) |=> state_q == ST_DRIVE)
    else $error("request did not start drive");
  a_end_target: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_DRIVE && endReq && !faultDetected) |=> state_q == (standbySelect ? ST_STANDBY : ST_IDLE))
    else $error("wrong state after playback");
  a_fault_idle: assert property (@(posedge clock) disable iff (rst)
    (faultDetected && state_q != ST_BOOT) |=> state_q == ST_IDLE) else $error("fault did not force idle");
  a_no_start_fault: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_IDLE && faultPending) |=> state_q != ST_DRIVE) else $error("started with fault pending");
  a_high_mode_idle: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_IDLE && operationMode > MODE_EDGE_STORE) |=> state_q == ST_IDLE) else $error("bad mode started");
  a_stage_restart: assert property (@(posedge clock) disable iff (rst)
    ($rose(stageOn_q)) |-> $past(restart_q) && $past(hpTick)) else $error("stage restarted early");
  a_zero_stage_off: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_DRIVE && hpTick && amplitude == LEVEL_ZERO) |=> !stageOn_q) else $error("zero level kept stage");
  a_switch_spacing: assert property (@(posedge clock) disable iff (rst)
    swTick_q |=> !swTick_q [*8]) else $error("switching ticks too close");
  a_polarity_step: assert property (@(posedge clock) disable iff (rst)
    (pol_q != $past(pol_q)) |-> $past(hpTick)) else $error("polarity moved off crossing");
  c_stream_drive: cover property (@(posedge clock) disable iff (rst)
    state_q == ST_DRIVE && driveMode_q == MODE_PWM_STREAM && stageOn_q);
  c_standby_return: cover property (@(posedge clock) disable iff (rst)
    state_q == ST_DRIVE ##1 state_q == ST_STANDBY);
  c_reverse_drive: cover property (@(posedge clock) disable iff (rst) driveValid && driveReverse);
endmodule
`default_nettype wire

/* logic/hpm_pkg.sv */
// Shared constants and types for the haptic playback mode controller
package hpm_pkg;
  typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_STANDBY, ST_DRIVE} hpm_state_t;
  localparam logic [2:0] MODE_INACTIVE   = 3'h0;
  localparam logic [2:0] MODE_REG_STREAM = 3'h1;
  localparam logic [2:0] MODE_PWM_STREAM = 3'h2;
  localparam logic [2:0] MODE_REG_STORE  = 3'h3;
  localparam logic [2:0] MODE_EDGE_STORE = 3'h4;
  localparam logic [1:0] EDGE_RISE       = 2'h0;
  localparam logic [1:0] EDGE_FALL       = 2'h1;
  localparam logic [1:0] EDGE_BOTH       = 2'h2;
  localparam int         CLOCK_PERIOD_PS = 5000;
  localparam int         BOOT_TIME_US    = 1500;
  localparam int         BOOT_CYCLES     = (BOOT_TIME_US * 1000000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam logic [31:0] CLOCK_FREQ_DHZ = 32'd2000000000;
  localparam logic [31:0] SWITCH_FREQ_DHZ = 32'd1875000;
  localparam int         WORD_W          = 11;
  localparam int         W_AMP_LSB       = 0;
  localparam int         W_EN_BIT        = 8;
  localparam int         W_PHASE_BIT     = 9;
  localparam int         W_REV_BIT       = 10;
  localparam logic [7:0] LEVEL_ZERO      = 8'h00;
  localparam logic [7:0] LEVEL_NEG_FULL  = 8'h80;
  localparam logic [6:0] LEVEL_POS_FULL  = 7'h7f;
  localparam logic [7:0] DUTY_MID        = 8'h80;
  localparam logic [7:0] DUTY_FULL       = 8'hff;
endpackage

/* logic/hpm_word_if.sv */
// Valid/ready word carrier between the sampler and the drive buffer
`timescale 1ns/1ps
`default_nettype none
interface hpm_word_if #(parameter int WIDTH = 11);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

/* logic/hpm_pair_buffer.sv */
// Small FIFO holding drive words between sampler and output stage
`timescale 1ns/1ps
`default_nettype none
module hpm_pair_buffer #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 2
) (
  input wire logic   clock,
  input wire logic   rst,
  hpm_word_if.sink   inPort,
  hpm_word_if.source outPort
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

  initial begin
    if (DEPTH < 2 || WIDTH < 1) $error("hpm_pair_buffer: DEPTH must be at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [PW:0]      count_q, count_d;
  logic             push, pop;

  // Honest full and empty seen by both sides
  assign inPort.ready  = (count_q != FULL_COUNT);
  assign outPort.valid = (count_q != '0);
  assign outPort.data  = mem_q[rdPtr_q];
  assign push = inPort.valid & inPort.ready;
  assign pop  = outPort.valid & outPort.ready;

  // Next pointers, count and storage
  always_comb begin
    mem_d   = mem_q;
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    count_d = count_q;
    if (push) begin
      mem_d[wrPtr_q] = inPort.data;
      wrPtr_d = (wrPtr_q == LAST_SLOT) ? '0 : wrPtr_q + 1'b1;
    end
    if (pop) begin
      rdPtr_d = (rdPtr_q == LAST_SLOT) ? '0 : rdPtr_q + 1'b1;
    end
    if (push && !pop) count_d = count_q + 1'b1;
    else if (pop && !push) count_d = count_q - 1'b1;
  end

  // Registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      mem_q   <= mem_d;
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  a_buf_no_overflow: assert property (@(posedge clock) disable iff (rst)
    count_q <= FULL_COUNT) else $error("buffer count above depth");
  a_buf_full_stall: assert property (@(posedge clock) disable iff (rst)
    (count_q == FULL_COUNT && !pop) |=> (count_q == FULL_COUNT)) else $error("full buffer lost a word");
  c_buf_full: cover property (@(posedge clock) disable iff (rst) count_q == FULL_COUNT);
endmodule
`default_nettype wire

/* tb/hpm_pwm_source.sv */
// Duty-cycle source model that drives the stream pin from its own link clock
`timescale 1ns/1ps
`default_nettype none
module hpm_pwm_source (
  input  wire logic [4:0] highTicks,
  output logic            pwmPin
);
  logic       linkClock;
  logic [3:0] tickCnt;

  // Free-running 80 ns link clock, phase unrelated to the core clock
  initial begin
    linkClock = 1'b0;
    tickCnt = 4'h0;
    #3.1;
    forever #40 linkClock = ~linkClock;
  end

  // Sixteen link ticks per frame
  always @(posedge linkClock) begin
    tickCnt <= tickCnt + 4'h1;
  end

  // High for the first highTicks of each frame, running from time zero
  assign pwmPin = ({1'b0, tickCnt} < highTicks);
endmodule
`default_nettype wire

/* tb/haptic_playback_mode_ctrl_tb.sv */
// Self-checking bench for the haptic playback mode controller
`timescale 1ns/1ps
`default_nettype none
module haptic_playback_mode_ctrl_tb;
  import hpm_pkg::*;
  typedef struct packed {
    logic       boost;
    logic       erm;
    logic [7:0] level;
    logic [7:0] amp;
    logic       rev;
    logic       ph;
  } hpm_row_t;
  localparam int BOOT = 20;
  localparam int LIMIT = 20000;
  logic        clock = 1'b0, rst = 1'b1, standbySelect = 1'b0, boostAssist = 1'b0, actuatorIsErm = 1'b1;
  logic        rapidStopEnable = 1'b1, sequenceLaunch = 1'b0, sequenceDone = 1'b0, driveReady = 1'b1;
  logic        faultDetected = 1'b0, faultPending = 1'b0, triggerStreamPin;
  logic [2:0]  operationMode = MODE_INACTIVE;
  logic [1:0]  edgeSelect = 2'h3;
  logic [4:0]  highTicks = 5'h0c;
  logic [7:0]  streamedDriveLevel = 8'h40, minDutyThreshold = 8'h00;
  logic [7:0]  nominalDriveCeiling = 8'h64, absoluteDriveCeiling = 8'hfe;
  logic [15:0] halfPeriodCycles = 16'h0028;
  hpm_state_t  systemState, rest;
  logic        sequencePlay, switchTick, polarityStatus, driveValid, driveStageOn, driveReverse, drivePhaseShift;
  logic        rapidStopPermit, wOn, wRev, wPh, wPol, wStop, pol;
  logic [7:0]  measuredDuty, driveAmplitude, transientCeiling, wAmp, wDuty, wCeil;
  int          n_fail = 0, comparisons = 0, cyc = 0, wCyc, t, t2;
  hpm_row_t    rows [6] = '{'{1'b0, 1'b1, 8'h40, 8'h80, 1'b0, 1'b0}, '{1'b0, 1'b1, 8'hc0, 8'h80, 1'b1, 1'b0},
                            '{1'b0, 1'b0, 8'h80, 8'hfe, 1'b0, 1'b1}, '{1'b0, 1'b0, 8'h7f, 8'hfe, 1'b0, 1'b0},
                            '{1'b1, 1'b1, 8'h7f, 8'h64, 1'b0, 1'b0}, '{1'b1, 1'b0, 8'h40, 8'h32, 1'b0, 1'b0}};

  hpm_playback_ctrl #(.BOOT_LEN(BOOT), .COUNT_W(16)) u_hpm_playback_ctrl (
    .clock(clock), .rst(rst), .operationMode(operationMode), .standbySelect(standbySelect),
    .boostAssist(boostAssist), .actuatorIsErm(actuatorIsErm), .rapidStopEnable(rapidStopEnable),
    .streamedDriveLevel(streamedDriveLevel), .nominalDriveCeiling(nominalDriveCeiling),
    .absoluteDriveCeiling(absoluteDriveCeiling), .minDutyThreshold(minDutyThreshold), .edgeSelect(edgeSelect),
    .sequenceLaunch(sequenceLaunch), .sequenceDone(sequenceDone), .faultDetected(faultDetected),
    .faultPending(faultPending), .halfPeriodCycles(halfPeriodCycles), .triggerStreamPin(triggerStreamPin),
    .driveReady(driveReady), .systemState(systemState), .sequencePlay(sequencePlay), .switchTick(switchTick),
    .polarityStatus(polarityStatus), .measuredDuty(measuredDuty), .driveValid(driveValid),
    .driveAmplitude(driveAmplitude), .driveStageOn(driveStageOn), .driveReverse(driveReverse),
    .drivePhaseShift(drivePhaseShift), .transientCeiling(transientCeiling), .rapidStopPermit(rapidStopPermit));

  hpm_pwm_source u_hpm_pwm_source (.highTicks(highTicks), .pwmPin(triggerStreamPin));

  // 200 MHz core clock
  initial begin
    forever #2.5 clock = ~clock;
  end

  // Cycle count and hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH time=%0t got=%h expected=%h", $time, got, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Waits a bounded number of cycles for a state, checks it, returns on a rising edge
  task automatic waitState(input hpm_state_t s, input int n);
    int k;
    k = 0;
    @(negedge clock);
    while (systemState !== s && k < n) begin
      @(negedge clock);
      k++;
    end
    check(systemState, s);
    @(posedge clock);
  endtask

  // Takes one drive word; the word leaves the buffer at the following rising edge
  task automatic getWord();
    int k;
    k = 0;
    @(negedge clock);
    while (driveValid !== 1'b1 && k < 400) begin
      @(negedge clock);
      k++;
    end
    check(driveValid, 1'b1);
    {wAmp, wOn, wRev, wPh, wPol} = {driveAmplitude, driveStageOn, driveReverse, drivePhaseShift, polarityStatus};
    {wDuty, wCeil, wStop} = {measuredDuty, transientCeiling, rapidStopPermit};
    wCyc = cyc;
    @(posedge clock);
  endtask

  task automatic skip(input int n);
    repeat (n) getWord();
  endtask

  task automatic waitTick(output int at);
    int k;
    k = 0;
    @(negedge clock);
    while (switchTick !== 1'b1 && k < 1200) begin
      @(negedge clock);
      k++;
    end
    at = cyc;
    @(posedge clock);
  endtask

  // Main sequence
  initial begin
    cycles(16);
    check(systemState, ST_BOOT);
    rst <= 1'b0;
    cycles(BOOT - 2);
    waitState(ST_BOOT, 0);
    waitState(ST_IDLE, 6);
    rest = ST_IDLE;
    // Every mode code with a launch pulse, then back to the resting state
    for (int m = 0; m < 8; m++) begin
      operationMode <= 3'(m);
      standbySelect <= m[0];
      sequenceLaunch <= 1'b1;
      @(negedge clock);
      check(sequencePlay, m == 3 || m == 4);
      @(posedge clock);
      sequenceLaunch <= 1'b0;
      if (m >= 1 && m <= 4) begin
        waitState(ST_DRIVE, 3);
        operationMode <= MODE_INACTIVE;
        sequenceDone <= 1'b1;
        cycles(1);
        sequenceDone <= 1'b0;
        rest = m[0] ? ST_STANDBY : ST_IDLE;
        waitState(rest, 3);
      end else begin
        cycles(3);
        waitState(rest, 0);
      end
    end
    // Level written beforehand, then register streaming
    operationMode <= MODE_REG_STREAM;
    waitState(ST_DRIVE, 3);
    foreach (rows[i]) begin
      {boostAssist, actuatorIsErm, streamedDriveLevel} <= {rows[i].boost, rows[i].erm, rows[i].level};
      skip(2);
      pol = wPol;
      getWord();
      check({wAmp, wOn, wRev, wPh}, {rows[i].amp, 1'b1, rows[i].rev, rows[i].ph});
      check(wPol, !pol);
      check(wCeil, rows[i].boost ? 8'hfe : 8'h64);
      check(wStop, 1'b1);
    end
    // Zero level switches the stage off; restart costs one half-period
    streamedDriveLevel <= 8'h00;
    getWord();
    check(wOn, 1'b0);
    streamedDriveLevel <= 8'h40;
    getWord();
    check(wOn, 1'b0);
    getWord();
    check({wOn, wAmp}, {1'b1, 8'h32});
    // Receiver stall: buffered words drain back to back
    driveReady <= 1'b0;
    cycles(200);
    driveReady <= 1'b1;
    getWord();
    t = wCyc;
    getWord();
    check(wCyc - t <= 2, 1'b1);
    check({wOn, wAmp}, {1'b1, 8'h32});
    // Fault drops to idle and pending faults hold off a restart
    faultDetected <= 1'b1;
    faultPending <= 1'b1;
    cycles(1);
    faultDetected <= 1'b0;
    waitState(ST_IDLE, 1);
    cycles(20);
    waitState(ST_IDLE, 0);
    faultPending <= 1'b0;
    waitState(ST_DRIVE, 3);
    // Pin streaming at 75 percent duty, source already running
    operationMode <= MODE_PWM_STREAM;
    boostAssist <= 1'b0;
    waitState(ST_STANDBY, 2);
    waitState(ST_DRIVE, 2);
    skip(16);
    check(wDuty, 8'hbf);
    check({wOn, wAmp, wRev}, {1'b1, 8'h7e, 1'b0});
    boostAssist <= 1'b1;
    skip(3);
    check({wOn, wAmp}, {1'b1, 8'h4a});
    minDutyThreshold <= 8'hc0;
    skip(3);
    check({wOn, wAmp}, {1'b0, 8'h00});
    minDutyThreshold <= 8'h00;
    getWord();
    check(wOn, 1'b0);
    getWord();
    check({wOn, wAmp}, {1'b1, 8'h4a});
    // Switching tick spacing while the pin stream runs
    waitTick(t);
    waitTick(t2);
    check((t2 - t == 1066) || (t2 - t == 1067), 1'b1);
    // Pin edges start only the edge-triggered store mode
    operationMode <= MODE_REG_STORE;
    edgeSelect <= EDGE_BOTH;
    standbySelect <= 1'b0;
    waitState(ST_IDLE, 4);
    cycles(600);
    waitState(ST_IDLE, 0);
    operationMode <= MODE_EDGE_STORE;
    waitState(ST_DRIVE, 300);
    conclude();
  end
endmodule
`default_nettype wire
